// File: src/lcd_cmd_consts.svh
// Constants for the display command decoder
// Functional notes
// - Display-enable zero blanks the display RAM read data (RD_DATA); blink and bank outputs keep running
// - Mode command 10x: enable, bias, drive mode
// - Bit6 zero loads six-bit RAM pointer
// - Code 1100 loads three-bit subaddress counter
// - Bank command ignored in three/four backplane
// - Code 1110 sets blink mode and rate
// - Three/four backplane forces normal blinking
// - No alternate-bank blinking in three/four backplane
// - Controller executes commands and holds status
// - Display data written at pointer, subaddress, bank
// - Bit7 set means another command follows
// - Pointer and subaddress advance after data
// - Only matching subaddress acknowledges and stores data
// - Blink rates divide clock by 768/1536/3072
`ifndef LCD_CMD_CONSTS_SVH
`define LCD_CMD_CONSTS_SVH
`define LCD_RAM_DEPTH     40
`define LCD_PTR_LAST      6'h27
`define LCD_BLINK_DIV1    12'd768
`define LCD_BLINK_DIV2    12'd1536
`define LCD_BLINK_DIV3    12'd3072
`define LCD_MODE_STATIC   2'h1
`define LCD_MODE_DUPLEX   2'h2
`define LCD_MODE_TRIPLEX  2'h3
`define LCD_MODE_QUAD     2'h0
`define LCD_RST_MODE      2'h0
`endif

// File: src/lcd_cmd_pkg.sv
// Types for the display command decoder
`default_nettype none
package lcd_cmd_pkg;
  typedef enum logic [0:0] {LCD_CMD, LCD_DATA} lcd_phase_e;
  typedef logic [1:0] lcd_mode_t;
  typedef logic [1:0] lcd_rate_t;
endpackage
`default_nettype wire

// File: src/lcd_cmd_decoder.sv
// Command decoder, status registers and display RAM loader
`include "lcd_cmd_consts.svh"
`default_nettype none
module lcd_cmd_decoder #(
  parameter int RAM_DEPTH = `LCD_RAM_DEPTH
) (
  input  wire logic             CLK,
  input  wire logic             RESET_N,
  input  wire logic             BYTE_VALID,
  input  wire logic [7:0]       BYTE_DATA,
  input  wire logic             XFER_START,
  input  wire logic             HW_SUBADDR_PIN_0,
  input  wire logic             HW_SUBADDR_PIN_1,
  input  wire logic             HW_SUBADDR_PIN_2,
  input  wire logic [5:0]       RD_ADDR,
  output logic                  BYTE_ACK,
  output logic                  DISPLAY_ENABLE,
  output logic                  BIAS_HALF,
  output lcd_cmd_pkg::lcd_mode_t DRIVE_MODE,
  output logic                  IN_BANK,
  output logic                  OUT_BANK,
  output logic                  BLINK_ALT,
  output lcd_cmd_pkg::lcd_rate_t BLINK_RATE_FIELD,
  output logic                  BLINK_PHASE,
  output logic                  SHOW_BANK,
  output logic [3:0]            RD_DATA,
  output logic [5:0]            DATA_POINTER,
  output logic [2:0]            SUBADDR_COUNT
);
  import lcd_cmd_pkg::*;

  // A depth of 64 would wrap the six-bit range compares to zero
  if (RAM_DEPTH < 1 || RAM_DEPTH > 63)
  begin : g_depth_check
    $error("RAM_DEPTH must be 1 to 63");
  end

  // Subaddress straps are pins: two flip-flops before use
  logic [2:0] strap_meta_reg;
  logic [2:0] strap_reg;
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      strap_meta_reg <= 3'h0;
      strap_reg      <= 3'h0;
    end
    else
    begin
      strap_meta_reg <= {HW_SUBADDR_PIN_2, HW_SUBADDR_PIN_1,
                         HW_SUBADDR_PIN_0};
      strap_reg      <= strap_meta_reg;
    end
  end

  lcd_phase_e phase_reg;
  lcd_mode_t  mode_reg;
  lcd_rate_t  rate_reg;
  logic       en_reg;
  logic       bias_reg;
  logic       in_bank_reg;
  logic       out_bank_reg;
  logic       alt_reg;
  logic [5:0] ptr_reg;
  logic [2:0] sub_reg;
  logic       ack_reg;

  // Command decode
  wire is_cmd   = BYTE_VALID && (phase_reg == LCD_CMD);
  wire is_data  = BYTE_VALID && (phase_reg == LCD_DATA);
  wire cmd_mode = is_cmd && (BYTE_DATA[6:5] == 2'b10);
  wire cmd_ptr  = is_cmd && !BYTE_DATA[6];
  wire cmd_dev  = is_cmd && (BYTE_DATA[6:3] == 4'b1100);
  wire cmd_blk  = is_cmd && (BYTE_DATA[6:3] == 4'b1110);
  wire cmd_bank = is_cmd && (BYTE_DATA[6:2] == 5'b11110);
  wire low_mux  = (mode_reg == `LCD_MODE_STATIC) ||
                  (mode_reg == `LCD_MODE_DUPLEX);
  wire bank_ok  = cmd_bank && low_mux;
  wire selected = (sub_reg == strap_reg);
  wire store    = is_data && selected;
  wire ptr_wrap = (ptr_reg == 6'(RAM_DEPTH - 1));
  wire [5:0] ptr_inc = ptr_wrap ? 6'h0 : ptr_reg + 6'h1;
  wire [2:0] sub_inc = ptr_wrap ? sub_reg + 3'h1 : sub_reg;

  // Phase: bit 7 clear on a command switches to display data
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      phase_reg <= LCD_CMD;
    else if (XFER_START)
      phase_reg <= LCD_CMD;
    else if (is_cmd && !BYTE_DATA[7])
      phase_reg <= LCD_DATA;
  end

  // Status registers held by the controller
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      en_reg   <= 1'b0;
      bias_reg <= 1'b0;
      mode_reg <= `LCD_RST_MODE;
    end
    else if (cmd_mode)
    begin
      en_reg   <= BYTE_DATA[3];
      bias_reg <= BYTE_DATA[2];
      mode_reg <= BYTE_DATA[1:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      in_bank_reg  <= 1'b0;
      out_bank_reg <= 1'b0;
    end
    else if (bank_ok)
    begin
      in_bank_reg  <= BYTE_DATA[1];
      out_bank_reg <= BYTE_DATA[0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      alt_reg  <= 1'b0;
      rate_reg <= 2'h0;
    end
    else if (cmd_blk)
    begin
      alt_reg  <= BYTE_DATA[2];
      rate_reg <= BYTE_DATA[1:0];
    end
  end

  // Pointer and subaddress: loaded by command, advanced by data.
  // Advance happens on every data byte so cascaded parts stay aligned.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ptr_reg <= 6'h0;
      sub_reg <= 3'h0;
    end
    else if (cmd_ptr)
      ptr_reg <= BYTE_DATA[5:0];
    else if (cmd_dev)
      sub_reg <= BYTE_DATA[2:0];
    else if (is_data)
    begin
      ptr_reg <= ptr_inc;
      sub_reg <= sub_inc;
    end
  end

  // Commands ack always; data acks only when selected
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      ack_reg <= 1'b0;
    else
      ack_reg <= is_cmd || store;
  end

  // Display RAM: one nibble per address, banks inside the nibble.
  // Static writes one bit, duplex two, higher modes one column nibble.
  logic [3:0] ram [RAM_DEPTH];
  logic [3:0] rd_reg;
  wire  [3:0] old_w = ram[ptr_reg];
  wire  [3:0] new_w =
    (mode_reg == `LCD_MODE_STATIC) ?
      (in_bank_reg ? {old_w[3], BYTE_DATA[7], old_w[1:0]}
                   : {old_w[3:1], BYTE_DATA[7]}) :
    (mode_reg == `LCD_MODE_DUPLEX) ?
      (in_bank_reg ? {BYTE_DATA[7:6], old_w[1:0]}
                   : {old_w[3:2], BYTE_DATA[7:6]}) :
    BYTE_DATA[7:4];
  wire ptr_ok = (ptr_reg < 6'(RAM_DEPTH));

  always_ff @(posedge CLK)
  begin
    if (store && ptr_ok)
      ram[ptr_reg] <= new_w;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      rd_reg <= 4'h0;
    else if (!en_reg)
      rd_reg <= 4'h0;
    else if (RD_ADDR < 6'(RAM_DEPTH))
      rd_reg <= ram[RD_ADDR];
    else
      rd_reg <= 4'h0;
  end

  // Blink divider
  logic [11:0] blink_cnt_reg;
  logic        blink_ph_reg;
  wire  [11:0] blink_div =
    (rate_reg == 2'h1) ? `LCD_BLINK_DIV1 :
    (rate_reg == 2'h2) ? `LCD_BLINK_DIV2 : `LCD_BLINK_DIV3;
  wire blink_tick = (blink_cnt_reg >= 12'(blink_div / 12'd2 - 12'd1));

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      blink_cnt_reg <= 12'h0;
      blink_ph_reg  <= 1'b0;
    end
    else if (rate_reg == 2'h0)
    begin
      blink_cnt_reg <= 12'h0;
      blink_ph_reg  <= 1'b0;
    end
    else if (blink_tick)
    begin
      blink_cnt_reg <= 12'h0;
      blink_ph_reg  <= ~blink_ph_reg;
    end
    else
      blink_cnt_reg <= blink_cnt_reg + 12'h1;
  end

  // Effective mode: alternate-bank blinking only in low-mux modes
  wire alt_eff = alt_reg && low_mux;
  logic alt_out_reg;
  logic show_reg;
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      alt_out_reg <= 1'b0;
      show_reg    <= 1'b0;
    end
    else
    begin
      alt_out_reg <= alt_eff;
      show_reg    <= (alt_eff && blink_ph_reg) ? ~out_bank_reg
                                                 : out_bank_reg;
    end
  end

  assign BYTE_ACK         = ack_reg;
  assign DISPLAY_ENABLE   = en_reg;
  assign BIAS_HALF        = bias_reg;
  assign DRIVE_MODE       = mode_reg;
  assign IN_BANK          = in_bank_reg;
  assign OUT_BANK         = out_bank_reg;
  assign BLINK_ALT        = alt_out_reg;
  assign BLINK_RATE_FIELD = rate_reg;
  assign BLINK_PHASE      = blink_ph_reg;
  assign SHOW_BANK        = show_reg;
  assign RD_DATA          = rd_reg;
  assign DATA_POINTER     = ptr_reg;
  assign SUBADDR_COUNT    = sub_reg;

  a_bank_ignored: assert property (@(posedge CLK) disable iff (!RESET_N)
    cmd_bank && !low_mux |=> $stable(in_bank_reg) && $stable(out_bank_reg))
    else $error("bank changed in high mux");
  a_alt_blocked: assert property (@(posedge CLK) disable iff (!RESET_N)
    !low_mux |=> !BLINK_ALT)
    else $error("alternate blink in high mux");
  a_ptr_load: assert property (@(posedge CLK) disable iff (!RESET_N)
    cmd_ptr |=> DATA_POINTER == $past(BYTE_DATA[5:0]))
    else $error("pointer not loaded");
  a_sub_load: assert property (@(posedge CLK) disable iff (!RESET_N)
    cmd_dev |=> SUBADDR_COUNT == $past(BYTE_DATA[2:0]))
    else $error("subaddress not loaded");
  a_data_phase: assert property (@(posedge CLK) disable iff (!RESET_N)
    is_cmd && !BYTE_DATA[7] && !XFER_START |=> phase_reg == LCD_DATA)
    else $error("no switch to data");
  a_start_cmd: assert property (@(posedge CLK) disable iff (!RESET_N)
    XFER_START |=> phase_reg == LCD_CMD)
    else $error("start did not return to command");
  a_ack_match: assert property (@(posedge CLK) disable iff (!RESET_N)
    is_data && !selected |=> !BYTE_ACK)
    else $error("unselected data acknowledged");
  a_blank_out: assert property (@(posedge CLK) disable iff (!RESET_N)
    !en_reg |=> RD_DATA == 4'h0)
    else $error("blank display shows data");
  a_ptr_adv: assert property (@(posedge CLK) disable iff (!RESET_N)
    is_data && !ptr_wrap |=> DATA_POINTER == $past(ptr_reg) + 6'h1)
    else $error("pointer did not advance");
endmodule // lcd_cmd_decoder
`default_nettype wire

// File: testbench/lcd_bus_master.sv
// Bus master model that writes command and display bytes
`default_nettype none
module lcd_bus_master (
  input  wire logic       CLK,
  input  wire logic       BYTE_ACK,
  output logic            BYTE_VALID,
  output logic [7:0]      BYTE_DATA,
  output logic            XFER_START
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    BYTE_VALID = 1'b0;
    BYTE_DATA  = 8'h00;
    XFER_START = 1'b0;
  end
  // Every transfer opens here, so its first byte is a command
  task automatic start();
    @(negedge CLK);
    XFER_START = 1'b1;
    @(negedge CLK);
    XFER_START = 1'b0;
  endtask
  // Idle data shows the inverse of the last byte so a stale value cannot pass
  task automatic send(input logic [7:0] b, input int gap, output logic ack);
    @(negedge CLK);
    BYTE_VALID = 1'b1;
    BYTE_DATA  = b;
    @(negedge CLK);
    ack        = BYTE_ACK;
    BYTE_VALID = 1'b0;
    BYTE_DATA  = ~b;
    repeat (gap) @(negedge CLK);
  endtask
endmodule // lcd_bus_master
`default_nettype wire

// File: testbench/lcd_command_decoder_tb_top.sv
// Self-checking bench for the display command decoder
`default_nettype none
module lcd_command_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lcd_cmd_pkg::*;
  int         seed        = 71383;
  int         miscompares = 0;
  int         n_checks    = 0;
  int         n;
  logic       clk, reset_n, byte_valid, xfer_start, byte_ack, ack;
  logic       display_enable, bias_half, in_bank, out_bank, blink_alt;
  logic       blink_phase, show_bank, ib, ob, a, eib, eob;
  logic [7:0] byte_data, d;
  logic [2:0] sa, r, s, subaddr_count;
  logic [5:0] rd_addr, data_pointer, p;
  logic [3:0] rd_data;
  lcd_mode_t  drive_mode, m;
  lcd_rate_t  blink_rate, rf;

  lcd_cmd_decoder lcd_cmd_decoder_inst (
    .CLK(clk), .RESET_N(reset_n), .BYTE_VALID(byte_valid),
    .BYTE_DATA(byte_data), .XFER_START(xfer_start),
    .HW_SUBADDR_PIN_0(sa[0]), .HW_SUBADDR_PIN_1(sa[1]),
    .HW_SUBADDR_PIN_2(sa[2]), .RD_ADDR(rd_addr), .BYTE_ACK(byte_ack),
    .DISPLAY_ENABLE(display_enable), .BIAS_HALF(bias_half),
    .DRIVE_MODE(drive_mode), .IN_BANK(in_bank), .OUT_BANK(out_bank),
    .BLINK_ALT(blink_alt), .BLINK_RATE_FIELD(blink_rate),
    .BLINK_PHASE(blink_phase), .SHOW_BANK(show_bank), .RD_DATA(rd_data),
    .DATA_POINTER(data_pointer), .SUBADDR_COUNT(subaddr_count)
  );
  lcd_bus_master lcd_bus_master_inst (
    .CLK(clk), .BYTE_ACK(byte_ack), .BYTE_VALID(byte_valid),
    .BYTE_DATA(byte_data), .XFER_START(xfer_start)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bank switching exists only with one or two backplanes
  function automatic logic banked(input lcd_mode_t v);
    return v == 2'h1 || v == 2'h2;
  endfunction

  function automatic logic [15:0] half_div(input lcd_rate_t v);
    return 16'd384 << (v - 2'h1);
  endfunction

  task automatic wait_toggle(output int c);
    logic q;
    q = blink_phase;
    c = 0;
    while (blink_phase === q && c < 4000)
    begin
      @(negedge clk);
      c++;
    end
    if (c >= 4000)
    begin
      miscompares++;
      end_sim();
    end
  endtask

  initial
  begin
    reset_n = 1'b0;
    sa      = 3'($random(seed));
    rd_addr = 6'h00;
    eib     = 1'b0;
    eob     = 1'b0;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    chk(display_enable, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      r    = 3'($random(seed));
      r[1] = i[2];
      m    = lcd_mode_t'(i);
      ib   = 1'($random(seed));
      ob   = 1'($random(seed));
      a    = 1'($random(seed));
      rf   = 2'($random(seed));
      p    = 6'($unsigned($random(seed)) % 40);
      s    = 3'($random(seed));
      if (banked(m))
      begin
        eib = ib;
        eob = ob;
      end
      lcd_bus_master_inst.start();
      lcd_bus_master_inst.send({1'b1, 2'b10, r, m}, 0, ack);
      lcd_bus_master_inst.send({1'b1, 5'b11110, ib, ob}, 1, ack);
      lcd_bus_master_inst.send({1'b1, 4'b1110, a, rf}, 0, ack);
      lcd_bus_master_inst.send({2'b10, p}, 2, ack);
      lcd_bus_master_inst.send({5'b01100, s}, 0, ack);
      chk(ack, 1'b1);
      chk(display_enable, r[1]);
      chk(bias_half, r[0]);
      chk(drive_mode, m);
      chk(in_bank, eib);
      chk(out_bank, eob);
      chk(blink_rate, rf);
      chk(blink_alt, a & banked(m));
      chk(data_pointer, p);
      chk(subaddr_count, s);
      chk(show_bank, eob);
    end
    $display("command test done");
    d = 8'($random(seed));
    lcd_bus_master_inst.start();
    lcd_bus_master_inst.send(8'hc9, 0, ack);
    lcd_bus_master_inst.send(8'hf8, 0, ack);
    lcd_bus_master_inst.send(8'he0, 0, ack);
    lcd_bus_master_inst.send(8'ha7, 0, ack);
    lcd_bus_master_inst.send({5'b01100, sa}, 0, ack);
    lcd_bus_master_inst.send(d, 0, ack);
    chk(ack, 1'b1);
    chk(data_pointer, 6'h00);
    chk(subaddr_count, 3'(sa + 3'h1));
    lcd_bus_master_inst.send(~d, 0, ack);
    chk(ack, 1'b0);
    chk(data_pointer, 6'h01);
    rd_addr = 6'h27;
    repeat (2) @(negedge clk);
    chk(rd_data[0], d[7]);
    lcd_bus_master_inst.start();
    lcd_bus_master_inst.send(8'h41, 0, ack);
    repeat (2) @(negedge clk);
    chk(rd_data, 4'h0);
    $display("data test done");
    for (int k = 1; k < 4; k++)
    begin
      lcd_bus_master_inst.start();
      lcd_bus_master_inst.send({5'b01110, 1'b0, 2'(k)}, 0, ack);
      wait_toggle(n);
      wait_toggle(n);
      chk(16'(n), half_div(2'(k)));
    end
    // Static mode, output bank 0: alternate blink shows bank 1 on phase 1
    lcd_bus_master_inst.start();
    lcd_bus_master_inst.send(8'h75, 0, ack);
    wait_toggle(n);
    @(negedge clk);
    chk(blink_alt, 1'b1);
    chk(show_bank, blink_phase);
    wait_toggle(n);
    @(negedge clk);
    chk(show_bank, blink_phase);
    lcd_bus_master_inst.start();
    lcd_bus_master_inst.send(8'h70, 0, ack);
    repeat (2) @(negedge clk);
    chk(blink_phase, 1'b0);
    chk(show_bank, 1'b0);
    $display("blink test done");
    end_sim();
  end
endmodule // lcd_command_decoder_tb_top
`default_nettype wire
